// ---- dv/current_limit_config_checker.sv ----
// assertion checker for the current limit configuration block
`timescale 1ns/1ps
`default_nettype none
module current_limit_config_checker
   import current_limit_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic high_side_on,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] sense_method,
   input wire logic limit_active,
   input wire logic fault_shutdown
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ---------------------------------------------
   // window position
   // ---------------------------------------------
   logic [7:0] win_q;
   logic [7:0] blank;
   logic in_win;
   assign in_win = (sense_method == 2'h2) ? high_side_on : !high_side_on;
   assign blank = (sense_method == 2'h0) ? 8'(BLANK_LONG_CYC) : 8'(BLANK_SHORT_CYC);
   always_ff @(posedge aclk) begin
      if (!aresetn || !in_win)
         win_q <= 8'h00;
      else if (win_q != 8'hFF)
         win_q <= win_q + 8'h01;
   end
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   chk_blank_sample: assert property (
      $changed(limit_active) |-> $past(win_q) == $past(blank))
      else $error("limit_active moved off the sample point");
   chk_one_sample: assert property (
      $changed(limit_active) |=> $stable(limit_active) [*8])
      else $error("limit_active moved twice in a row");
   chk_fault_moment: assert property (
      $rose(fault_shutdown) |-> ($past(win_q) - $past(blank)) <= 8'h01)
      else $error("shutdown rose away from a sample");
   chk_fault_clear: assert property (
      $fell(fault_shutdown) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("shutdown fell without a write");
   chk_method_legal: assert property (
      sense_method != 2'h3)
      else $error("method code 3 seen");
   chk_bvalid_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   chk_rvalid_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer not held");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no rvalid after address");
   chk_awready_pulse: assert property (
      s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than a cycle");
   cover property ($rose(limit_active));
   cover property ($rose(fault_shutdown));
   cover property (s_axi_bvalid && s_axi_bready);
endmodule // current_limit_config_checker
`default_nettype wire

// ---- dv/current_limit_partner.sv ----
// power stage model: gate timing and current comparators
`timescale 1ns/1ps
`default_nettype none
module current_limit_partner #(
   parameter int HI_CYC = 40,
   parameter int LO_CYC = 200,
   parameter int RING_CYC = 20
) (
   input wire logic aclk,
   input wire logic over_cmd,
   input wire logic under_cmd,
   output logic high_side_on,
   output logic sense_over,
   output logic sense_under
);
   // ---------------------------------------------
   // gate timing and comparators
   // ---------------------------------------------
   int cnt_q = 0;
   logic junk_q = 1'b0;
   logic quiet;
   always_ff @(posedge aclk) begin
      cnt_q <= (cnt_q == HI_CYC + LO_CYC - 1) ? 0 : cnt_q + 1;
      junk_q <= !junk_q;
   end
   assign high_side_on = (cnt_q < HI_CYC);
   // comparators toggle while the switch node rings, so early sampling shows
   assign quiet = (cnt_q >= HI_CYC + RING_CYC);
   assign sense_over = quiet ? over_cmd : junk_q;
   assign sense_under = quiet ? under_cmd : !junk_q;
endmodule // current_limit_partner
`default_nettype wire

// ---- dv/tb_current_limit_config.sv ----
// testbench for the current limit configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_current_limit_config;
   import current_limit_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, over_cmd = 1'b0, under_cmd = 1'b0;
   logic [1:0] limit_select_pin_a = 2'h0, limit_select_pin_b = 2'h0;
   logic [4:0] limit_select_pin_b_res = 5'h00;
   logic high_side_on, sense_over, sense_under;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, sense_method;
   logic [31:0] s_axi_rdata;
   logic [6:0] limit_threshold_voltage;
   logic limit_active, fault_shutdown, irq;
   int n_errors = 0, n_checks = 0;
   current_limit_config current_limit_config_i (.aclk, .aresetn, .limit_select_pin_a,
      .limit_select_pin_b, .limit_select_pin_b_res, .high_side_on, .sense_over, .sense_under,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .limit_threshold_voltage, .sense_method,
      .limit_active, .fault_shutdown, .irq);
   current_limit_partner current_limit_partner_i (.aclk, .over_cmd, .under_cmd,
      .high_side_on, .sense_over, .sense_under);
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic do_reset(input logic [1:0] a, input logic [1:0] b, input logic [4:0] r);
      limit_select_pin_a <= a;
      limit_select_pin_b <= b;
      limit_select_pin_b_res <= r;
      aresetn <= 1'b0;
      cyc(6);
      aresetn <= 1'b1;
      cyc(8);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check(s_axi_bresp, RESP_OKAY, "write response");
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [1:0] resp, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      check(s_axi_rresp, resp, "read response");
   endtask
   // one switching period with the comparator held at v through the window
   task automatic win(input logic v);
      over_cmd <= v;
      @(posedge high_side_on);
      @(posedge aclk);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_threshold();
      for (int a = 0; a < 3; a++)
         for (int b = 0; b < 3; b++) begin
            do_reset(a[1:0], b[1:0], 5'h00);
            check(limit_threshold_voltage, 20 + 10 * a + 30 * b, "threshold");
            check(sense_method, SENSE_ON_RES, "default method");
         end
   endtask
   task automatic t_straps();
      logic [31:0] d;
      for (int b = 0; b < 3; b++) begin
         do_reset(2'h3, b[1:0], 5'h00);
         check(sense_method, b, "strap method");
         axi_rd(STATUS_OFFS, RESP_OKAY, d);
         check(d[15:12], 5, "strap count");
      end
   endtask
   task automatic t_steps();
      logic [31:0] d;
      for (int s = 0; s < 24; s++) begin
         do_reset(2'h3, 2'h3, s[4:0]);
         check(sense_method, s / 8, "step method");
         axi_rd(STATUS_OFFS, RESP_OKAY, d);
         check(d[15:12], 2 * (s % 8) + 1, "step count");
      end
      axi_rd(8'h40, RESP_SLVERR, d);
      check(d, 32'h0000_0000, "unmapped data");
   endtask
   task automatic t_fault();
      logic [31:0] d;
      do_reset(2'h3, 2'h3, 5'h00);
      axi_wr(CTRL_OFFS, 32'h0000_0008);
      @(posedge high_side_on);
      win(1'b1);
      check(limit_active, 1'b1, "over seen");
      check(irq, 1'b0, "masked irq");
      win(1'b0);
      check(limit_active, 1'b0, "clean sample");
      win(1'b1);
      check(fault_shutdown, 1'b0, "count cleared");
      axi_wr(IRQ_MASK_OFFS, 32'h0000_0007);
      cyc(2);
      check(irq, 1'b1, "unmasked irq");
      win(1'b1);
      check(fault_shutdown, 1'b1, "fault");
      over_cmd <= 1'b0;
      axi_rd(IRQ_STATUS_OFFS, RESP_OKAY, d);
      check(d, 32'h0000_0005, "fault status");
      axi_rd(IRQ_STATUS_OFFS, RESP_OKAY, d);
      check(d, 32'h0000_0000, "status cleared");
      cyc(2);
      check(irq, 1'b0, "irq cleared");
      axi_wr(CTRL_OFFS, 32'h0000_0018);
      cyc(2);
      check(fault_shutdown, 1'b0, "restart");
      under_cmd <= 1'b1;
      win(1'b0);
      check(limit_active, 1'b0, "under does not limit");
      win(1'b0);
      check(fault_shutdown, 1'b1, "under fault");
      under_cmd <= 1'b0;
      axi_rd(IRQ_STATUS_OFFS, RESP_OKAY, d);
      check(d, 32'h0000_0006, "under status");
   endtask
   task automatic t_override();
      logic [31:0] d;
      axi_wr(CTRL_OFFS, 32'h0000_0006);
      cyc(2);
      check(sense_method, SENSE_UP_SLOPE, "override");
      axi_rd(CTRL_OFFS, RESP_OKAY, d);
      check(d[2:0], 3'h6, "control readback");
      axi_wr(CTRL_OFFS, 32'h0000_0003);
      cyc(2);
      check(sense_method, SENSE_ON_RES, "override off");
      axi_wr(CTRL_OFFS, 32'h0000_0007);
      cyc(2);
      check(sense_method, SENSE_ON_RES, "code 3 ignored");
      axi_wr(THR_OFFS, 32'h0000_00AD);
      cyc(2);
      check(limit_threshold_voltage, 7'h2D, "threshold override");
      axi_wr(THR_OFFS, 32'h0000_0000);
      cyc(2);
      check(limit_threshold_voltage, THR_DEFAULT_MV, "strap threshold");
   endtask
   // ---------------------------------------------
   // run control
   // ---------------------------------------------
   initial begin
      forever #2 aclk = ~aclk;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      finish_test();
   end
   initial begin
      @(posedge aclk);
      t_threshold();
      t_straps();
      t_steps();
      t_fault();
      t_override();
      finish_test();
   end
endmodule // tb_current_limit_config
bind current_limit_config current_limit_config_checker current_limit_config_checker_i (
   .aclk, .aresetn, .high_side_on, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .sense_method, .limit_active, .fault_shutdown);
`default_nettype wire

// ---- logic/current_limit_config.sv ----
// current limit configuration, sampling and fault qualification with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module current_limit_config
   import current_limit_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] limit_select_pin_a,
   input wire logic [1:0] limit_select_pin_b,
   input wire logic [4:0] limit_select_pin_b_res,
   input wire logic high_side_on,
   input wire logic sense_over,
   input wire logic sense_under,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [6:0] limit_threshold_voltage,
   output logic [1:0] sense_method,
   output logic limit_active,
   output logic fault_shutdown,
   output logic irq
);
   import current_limit_pkg::*;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [BLANK_W-1:0] blank_cycles(input sense_e m);
      blank_cycles = (m == SENSE_ON_RES) ? BLANK_W'(BLANK_LONG_CYC) : BLANK_W'(BLANK_SHORT_CYC);
   endfunction

   function automatic logic [1:0] tri_index(input logic [1:0] s);
      tri_index = (s == STRAP_RES) ? 2'h1 : s;
   endfunction

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [10:0] pin_meta_q;
   logic [10:0] pin_sync_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= {sense_under, sense_over, limit_select_pin_b_res,
                        limit_select_pin_b, limit_select_pin_a};
         pin_sync_q <= pin_meta_q;
      end
   end

   // ----------------------------------------------------------------------
   // strap capture and decode
   // ----------------------------------------------------------------------
   // straps are caught once, three cycles after release, so the synchroniser has settled
   logic [1:0] strap_wait_q;
   logic [1:0] strap_a_q;
   logic [1:0] strap_b_q;
   logic [4:0] strap_b_res_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_wait_q <= 2'h0;
         strap_a_q <= STRAP_LOW;
         strap_b_q <= STRAP_LOW;
         strap_b_res_q <= 5'h00;
      end else if (strap_wait_q != 2'h3) begin
         strap_wait_q <= strap_wait_q + 2'h1;
         if (strap_wait_q == 2'h2) begin
            strap_a_q <= pin_sync_q[1:0];
            strap_b_q <= pin_sync_q[3:2];
            strap_b_res_q <= pin_sync_q[8:4];
         end
      end
   end

   sense_e strap_method;
   logic [3:0] allowed_viol;
   logic [6:0] strap_thr;
   logic [4:0] res_step;
   always_comb begin
      res_step = strap_b_res_q & (RES_STEPS_PER_RANGE - 5'h01);
      strap_method = SENSE_ON_RES;
      allowed_viol = DEFAULT_VIOLATIONS;
      strap_thr = THR_BASE_MV + 7'(THR_STEP_MV * 7'(tri_index(strap_a_q)))
                  + 7'(THR_STEP_MV * 7'h03 * 7'(tri_index(strap_b_q)));
      if (strap_a_q != STRAP_RES) begin
         strap_method = SENSE_ON_RES;
      end else begin
         strap_thr = THR_DEFAULT_MV;
         case (strap_b_q)
            STRAP_LOW: strap_method = SENSE_ON_RES;
            STRAP_OPEN: strap_method = SENSE_DOWN_SLOPE;
            STRAP_HIGH: strap_method = SENSE_UP_SLOPE;
            default: begin
               if (strap_b_res_q < 5'h08) begin
                  strap_method = SENSE_ON_RES;
               end else if (strap_b_res_q < 5'h10) begin
                  strap_method = SENSE_DOWN_SLOPE;
               end else begin
                  strap_method = SENSE_UP_SLOPE;
               end
               allowed_viol = {res_step[2:0], 1'b1};
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [31:0] thr_q;
   logic [2:0] irq_status_q;
   logic [2:0] irq_mask_q;
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   logic rd_fire;
   logic status_read;
   logic restart_pulse;
   logic [2:0] events;

   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign status_read = rd_fire && (s_axi_araddr == IRQ_STATUS_OFFS);
   assign restart_pulse = wr_fire && (aw_addr_q == CTRL_OFFS) && w_strb_q[0]
                          && w_data_q[CTRL_RESTART_BIT];

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[i*8 +: 8] = d[i*8 +: 8];
         end
      end
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q == CTRL_OFFS || aw_addr_q == THR_OFFS
                            || aw_addr_q == IRQ_MASK_OFFS || aw_addr_q == STATUS_OFFS
                            || aw_addr_q == IRQ_STATUS_OFFS) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RESET;
         thr_q <= THR_RESET;
         irq_mask_q <= IRQ_MASK_RESET;
      end else if (wr_fire) begin
         case (aw_addr_q)
            CTRL_OFFS: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
            THR_OFFS: thr_q <= merge(thr_q, w_data_q, w_strb_q);
            IRQ_MASK_OFFS: irq_mask_q <= w_strb_q[0] ? w_data_q[2:0] : irq_mask_q;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------------
   logic [4:0] viol_cnt_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
               CTRL_OFFS: s_axi_rdata <= {28'h0, ctrl_q[CTRL_LATCH_BIT:0]};
               THR_OFFS: s_axi_rdata <= {24'h0, thr_q[7:0]};
               STATUS_OFFS: s_axi_rdata <= {9'h000, viol_cnt_q, fault_shutdown, limit_active,
                                            allowed_viol, limit_threshold_voltage, 1'b0,
                                            strap_method, sense_method};
               IRQ_STATUS_OFFS: s_axi_rdata <= {29'h0, irq_status_q};
               IRQ_MASK_OFFS: s_axi_rdata <= {29'h0, irq_mask_q};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // effective configuration
   // ----------------------------------------------------------------------
   sense_e eff_method;
   always_comb begin
      eff_method = strap_method;
      if (ctrl_q[CTRL_METHOD_OVR_BIT] && ctrl_q[1:0] != 2'h3) begin
         eff_method = sense_e'(ctrl_q[1:0]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sense_method <= SENSE_ON_RES;
         limit_threshold_voltage <= THR_BASE_MV;
      end else begin
         sense_method <= eff_method;
         limit_threshold_voltage <= thr_q[THR_OVR_BIT] ? thr_q[6:0] : strap_thr;
      end
   end

   // ----------------------------------------------------------------------
   // sampling window and blanking
   // ----------------------------------------------------------------------
   // up-slope senses while the high side conducts, the others while the low side does
   logic in_window;
   logic window_q;
   logic sampled_q;
   logic [BLANK_W-1:0] blank_q;
   logic sample_now;
   assign in_window = (eff_method == SENSE_UP_SLOPE) ? high_side_on : !high_side_on;
   assign sample_now = in_window && window_q && !sampled_q && (blank_q == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         window_q <= 1'b0;
         sampled_q <= 1'b0;
         blank_q <= '0;
      end else begin
         window_q <= in_window;
         if (in_window && !window_q) begin
            blank_q <= blank_cycles(eff_method) - BLANK_W'(1);
            sampled_q <= 1'b0;
         end else if (blank_q != '0) begin
            blank_q <= blank_q - BLANK_W'(1);
         end
         if (sample_now) begin
            sampled_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // violation counting and fault action
   // ----------------------------------------------------------------------
   logic viol;
   logic fault_hit;
   assign viol = pin_sync_q[9] || pin_sync_q[10];
   assign fault_hit = sample_now && viol && (viol_cnt_q >= {1'b0, allowed_viol});

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         viol_cnt_q <= 5'h00;
         limit_active <= 1'b0;
      end else if (sample_now) begin
         limit_active <= pin_sync_q[9];
         if (!viol || fault_hit) begin
            viol_cnt_q <= 5'h00;
         end else begin
            viol_cnt_q <= viol_cnt_q + 5'h01;
         end
      end
   end

   // latched shutdown holds the drivers off until software asks for a restart
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_shutdown <= 1'b0;
      end else if (fault_hit && ctrl_q[CTRL_LATCH_BIT]) begin
         fault_shutdown <= 1'b1;
      end else if (restart_pulse) begin
         fault_shutdown <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------------
   always_comb begin
      events = 3'h0;
      events[IRQ_OVER_BIT] = fault_hit && pin_sync_q[9];
      events[IRQ_UNDER_BIT] = fault_hit && !pin_sync_q[9];
      events[IRQ_VIOL_BIT] = sample_now && viol;
   end

   // a set in the cycle of the clearing read survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_q <= 3'h0;
         irq <= 1'b0;
      end else begin
         irq_status_q <= (status_read ? 3'h0 : irq_status_q) | events;
         irq <= |(((status_read ? 3'h0 : irq_status_q) | events) & irq_mask_q);
      end
   end

endmodule // current_limit_config
`default_nettype wire

// ---- logic/current_limit_pkg.sv ----
// constants, encodings and register map of the current limit configuration block
package current_limit_pkg;

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int BLANK_LONG_NS = 672;
   localparam int BLANK_SHORT_NS = 352;
   localparam int BLANK_LONG_CYC = (BLANK_LONG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BLANK_SHORT_CYC = (BLANK_SHORT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int BLANK_W = 8;

   // ----------------------------------------------------------------------
   // strap and method encodings
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {STRAP_LOW, STRAP_OPEN, STRAP_HIGH, STRAP_RES} strap_e;
   typedef enum logic [1:0] {SENSE_ON_RES, SENSE_DOWN_SLOPE, SENSE_UP_SLOPE} sense_e;
   localparam logic [4:0] RES_STEPS_PER_RANGE = 5'h08;
   localparam logic [3:0] DEFAULT_VIOLATIONS = 4'h5;
   localparam logic [6:0] THR_BASE_MV = 7'h14;
   localparam logic [6:0] THR_STEP_MV = 7'h0A;
   localparam logic [6:0] THR_DEFAULT_MV = 7'h32;

   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFS = 8'h00;
   localparam logic [7:0] THR_OFFS = 8'h04;
   localparam logic [7:0] STATUS_OFFS = 8'h08;
   localparam logic [7:0] IRQ_STATUS_OFFS = 8'h0C;
   localparam logic [7:0] IRQ_MASK_OFFS = 8'h10;
   localparam int CTRL_METHOD_LSB = 0;
   localparam int CTRL_METHOD_OVR_BIT = 2;
   localparam int CTRL_LATCH_BIT = 3;
   localparam int CTRL_RESTART_BIT = 4;
   localparam int THR_OVR_BIT = 7;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] THR_RESET = 32'h0000_0000;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   localparam int IRQ_OVER_BIT = 0;
   localparam int IRQ_UNDER_BIT = 1;
   localparam int IRQ_VIOL_BIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
